// file: hw/apb_decode.sv
// apb access decode: strobes and register index for one transfer
`timescale 1ns/1ns
`default_nettype none
module apb_decode
    import pll_dma_cfg_pkg::*;
(
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    // decoded
    output logic wr_stb,
    output logic rd_stb,
    output logic [5:0] word_idx,
    output logic mapped
);
    // a refused (unmapped or misaligned) access gets no write strobe, so it changes nothing
    always_comb begin
        mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_PROC_ID);
        wr_stb = psel && penable && pwrite && mapped;
        rd_stb = psel && !penable && !pwrite;
        word_idx = paddr[7:2];
    end
endmodule // apb_decode
`default_nettype wire

// file: hw/pll_dma_cfg_pkg.sv
// package: offsets, field layouts and reset values of the pll and dma boot configuration bank
package pll_dma_cfg_pkg;
    // byte offsets, chosen for this bank
    localparam logic [7:0] OFS_PLL_SET_BASE = 8'h00;   // setting/bypass of pll n at base + 8*n
    localparam logic [7:0] OFS_PLL_DIV_BASE = 8'h04;   // dividers of pll n at base + 8*n
    localparam logic [7:0] OFS_DMA_CTRL = 8'h20;
    localparam logic [7:0] OFS_DMA_ADDR = 8'h24;
    localparam logic [7:0] OFS_RESTORE = 8'h28;
    localparam logic [7:0] OFS_CHIP_ID = 8'h2C;
    localparam logic [7:0] OFS_PROC_ID = 8'h30;
    localparam int NUM_PLL = 4;
    localparam int PLL_CPU = 0;
    // field positions
    localparam int SET_LSB = 16;
    localparam int SET_W = 13;
    localparam int BYP_BIT = 0;
    localparam int CPU_RO_BIT = 5;
    localparam int OD_LSB = 8;
    localparam int OD_W = 4;
    localparam int REF_LSB = 0;
    localparam int REF_W = 6;
    localparam int IRQ_NS_LSB = 16;
    localparam int PER_NS_LSB = 8;
    localparam int MGR_NS_BIT = 4;
    localparam int BOOT_ADDR_BIT = 0;
    // writable masks
    localparam logic [31:0] SET_REG_MASK = 32'h1FFF_0001;
    localparam logic [31:0] DIV_REG_MASK = 32'h0000_0F3F;
    localparam logic [31:0] DMA_CTRL_MASK = 32'h000F_0311;
    // reset values, index = pll (cpu, ddr, display, sys)
    localparam logic [12:0] SET_RST [NUM_PLL] = '{13'h022F, 13'h00BF, 13'h01CD, 13'h022F};
    localparam logic [3:0] OD_RST [NUM_PLL] = '{4'h1, 4'h5, 4'hD, 4'hD};
    localparam logic [5:0] REF_RST [NUM_PLL] = '{6'h0D, 6'h03, 6'h09, 6'h0D};
    localparam logic [31:0] DMA_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] DMA_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] RESTORE_KEY = 32'hA50F_F0FA;
    // identification values, arbitrary
    localparam logic [31:0] CHIP_ID_VAL = 32'h1234_5678;
    localparam logic [31:0] PROC_ID_VAL = 32'h8765_4321;
endpackage

// file: hw/pll_dma_cfg_regs.sv
// pll and dma boot configuration register bank with apb slave
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module pll_dma_cfg_regs
    import pll_dma_cfg_pkg::*;
(
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // read-only status bit of the cpu pll register
    input wire logic cpu_pll_status,
    // pll configuration outputs
    output logic [NUM_PLL-1:0][12:0] pll_setting,
    output logic [NUM_PLL-1:0] pll_bypass,
    output logic [NUM_PLL-1:0][3:0] pll_output_divider,
    output logic [NUM_PLL-1:0][5:0] pll_reference_divider,
    // dma controller boot configuration
    output logic [3:0] dma_irq_nonsecure,
    output logic [1:0] dma_periph_req_nonsecure,
    output logic dma_manager_nonsecure,
    output logic dma_boot_from_address,
    output logic [31:0] dma_boot_address
);
    logic wr_stb;
    logic rd_stb;
    logic [5:0] word_idx;
    logic mapped;
    logic xfer_ok_r;
    logic wr_go;
    logic restore;
    logic [31:0] wmask;
    logic [31:0] rd_nxt;
    logic stat_s1_r;
    logic stat_s2_r;
    logic [31:0] set_r [NUM_PLL];
    logic [31:0] div_r [NUM_PLL];
    logic [31:0] dma_ctrl_r;
    logic [31:0] dma_addr_r;
    logic [31:0] prdata_r;
    logic pslverr_r;

    apb_decode apb_decode_inst (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .word_idx(word_idx),
        .mapped(mapped)
    );

    // byte enables expand to a bit mask
    function automatic logic [31:0] lane_mask(input logic [3:0] s);
        lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // merge write data into a register under the writable mask
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    // word index of the first register of pll n
    function automatic logic [5:0] set_idx(input int n);
        set_idx = 6'((OFS_PLL_SET_BASE >> 2) + 2 * n);
    endfunction

    // word index of the second register of pll n
    function automatic logic [5:0] div_idx(input int n);
        div_idx = 6'((OFS_PLL_DIV_BASE >> 2) + 2 * n);
    endfunction

    assign wmask = lane_mask(pstrb);
    // a write lands only at the edge that completes the transfer
    assign wr_go = wr_stb && pready;
    // key must be whole word; a partial write cannot restore
    assign restore = wr_go && (word_idx == OFS_RESTORE[7:2])
                     && (pstrb == 4'hF) && (pwdata == RESTORE_KEY);

    // a setup cycle that fell while frozen costs one extra access cycle,
    // so read data and error status are always captured before pready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xfer_ok_r <= 1'b0;
        end else if (clk_en) begin
            xfer_ok_r <= psel && !(penable && xfer_ok_r);
        end
    end

    // status pin is from another domain, two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_s1_r <= 1'b0;
            stat_s2_r <= 1'b0;
        end else if (clk_en) begin
            stat_s1_r <= cpu_pll_status;
            stat_s2_r <= stat_s1_r;
        end
    end

    // pll register pairs, one generate slice per pll
    for (genvar g = 0; g < NUM_PLL; g++) begin : g_pll
        localparam logic [5:0] SET_IDX = set_idx(g);
        localparam logic [5:0] DIV_IDX = div_idx(g);
        localparam logic [31:0] SET_DEF = {3'b000, SET_RST[g], 15'h0000, 1'b0};
        localparam logic [31:0] DIV_DEF = {20'h00000, OD_RST[g], 2'b00, REF_RST[g]};

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                set_r[g] <= SET_DEF;
            end else if (clk_en) begin
                if (restore) begin
                    set_r[g] <= SET_DEF;
                end else if (wr_go && word_idx == SET_IDX) begin
                    set_r[g] <= merge(set_r[g], pwdata, wmask & SET_REG_MASK);
                end
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                div_r[g] <= DIV_DEF;
            end else if (clk_en) begin
                if (restore) begin
                    div_r[g] <= DIV_DEF;
                end else if (wr_go && word_idx == DIV_IDX) begin
                    div_r[g] <= merge(div_r[g], pwdata, wmask & DIV_REG_MASK);
                end
            end
        end

        // static drive to the pll
        assign pll_setting[g] = set_r[g][SET_LSB +: SET_W];
        assign pll_bypass[g] = set_r[g][BYP_BIT];
        assign pll_output_divider[g] = div_r[g][OD_LSB +: OD_W];
        assign pll_reference_divider[g] = div_r[g][REF_LSB +: REF_W];
    end

    // dma boot control and boot address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ctrl_r <= DMA_CTRL_RST;
            dma_addr_r <= DMA_ADDR_RST;
        end else if (clk_en) begin
            if (restore) begin
                dma_ctrl_r <= DMA_CTRL_RST;
                dma_addr_r <= DMA_ADDR_RST;
            end else if (wr_go && word_idx == OFS_DMA_CTRL[7:2]) begin
                dma_ctrl_r <= merge(dma_ctrl_r, pwdata, wmask & DMA_CTRL_MASK);
            end else if (wr_go && word_idx == OFS_DMA_ADDR[7:2]) begin
                dma_addr_r <= merge(dma_addr_r, pwdata, wmask);
            end
        end
    end

    // the dma controller samples these as it leaves reset, so they never pulse
    assign dma_irq_nonsecure = dma_ctrl_r[IRQ_NS_LSB +: 4];
    assign dma_periph_req_nonsecure = dma_ctrl_r[PER_NS_LSB +: 2];
    assign dma_manager_nonsecure = dma_ctrl_r[MGR_NS_BIT];
    assign dma_boot_from_address = dma_ctrl_r[BOOT_ADDR_BIT];
    assign dma_boot_address = dma_addr_r;

    // read mux; cpu bit 5 reflects the synchronised status, writes never reach it
    always_comb begin
        rd_nxt = 32'h0000_0000;
        for (int i = 0; i < NUM_PLL; i++) begin
            if (word_idx == set_idx(i)) begin
                rd_nxt = set_r[i];
            end
            if (word_idx == div_idx(i)) begin
                rd_nxt = div_r[i];
            end
        end
        if (word_idx == set_idx(PLL_CPU)) begin
            rd_nxt[CPU_RO_BIT] = stat_s2_r;
        end
        if (word_idx == OFS_DMA_CTRL[7:2]) begin
            rd_nxt = dma_ctrl_r;
        end
        if (word_idx == OFS_DMA_ADDR[7:2]) begin
            rd_nxt = dma_addr_r;
        end
        if (word_idx == OFS_CHIP_ID[7:2]) begin
            rd_nxt = CHIP_ID_VAL;
        end
        if (word_idx == OFS_PROC_ID[7:2]) begin
            rd_nxt = PROC_ID_VAL;
        end
    end

    // read data captured in the first running cycle of a read, held through access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (clk_en && psel && !pwrite && !xfer_ok_r) begin
            prdata_r <= mapped ? rd_nxt : 32'h0000_0000;
        end
    end

    // unmapped or misaligned addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_r <= 1'b0;
        end else if (clk_en && psel && !xfer_ok_r) begin
            pslverr_r <= !mapped;
        end
    end

    assign prdata = prdata_r;
    assign pready = clk_en && xfer_ok_r; // a frozen block stalls the bus
    assign pslverr = pslverr_r && psel && penable;

    // assertions
    logic [5:0] cpu_set_idx;
    assign cpu_set_idx = set_idx(PLL_CPU);

    property p_restore_defaults;
        @(posedge pclk) disable iff (!presetn)
        restore |=> (pll_setting[0] == SET_RST[0]) && (pll_setting[1] == SET_RST[1])
                    && !pll_bypass[3] && (pll_output_divider[2] == OD_RST[2]) && (dma_boot_address == 32'h0);
    endproperty
    a_restore_defaults: assert property (p_restore_defaults) else $error("restore key did not reload defaults");

    property p_bad_key;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && word_idx == OFS_RESTORE[7:2] && pwdata != RESTORE_KEY)
            |=> $stable(dma_ctrl_r) && $stable(pll_setting);
    endproperty
    a_bad_key: assert property (p_bad_key) else $error("wrong key changed configuration");

    property p_set_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && word_idx == set_idx(1) && pstrb == 4'hF && !restore)
            |=> pll_setting[1] == $past(pwdata[28:16]) && pll_bypass[1] == $past(pwdata[0]);
    endproperty
    a_set_write: assert property (p_set_write) else $error("ddr pll setting write lost");

    property p_div_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && word_idx == div_idx(3) && pstrb == 4'hF && !restore)
            |=> pll_output_divider[3] == $past(pwdata[11:8]) && pll_reference_divider[3] == $past(pwdata[5:0]);
    endproperty
    a_div_write: assert property (p_div_write) else $error("sys pll divider write lost");

    property p_ro_bit;
        @(posedge pclk) disable iff (!presetn)
        (rd_stb && clk_en && mapped && word_idx == cpu_set_idx) |=> prdata[CPU_RO_BIT] == $past(stat_s2_r);
    endproperty
    a_ro_bit: assert property (p_ro_bit) else $error("cpu pll bit 5 not from status");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        ##1 (set_r[1][31:29] == 3'b000) && (div_r[0][31:12] == 20'h0) && (dma_ctrl_r[31:20] == 12'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits stored");

    property p_dma_ctrl;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && word_idx == OFS_DMA_CTRL[7:2] && pstrb == 4'hF && !restore)
            |=> dma_irq_nonsecure == $past(pwdata[19:16]) && dma_periph_req_nonsecure == $past(pwdata[9:8])
                && dma_manager_nonsecure == $past(pwdata[4]) && dma_boot_from_address == $past(pwdata[0]);
    endproperty
    a_dma_ctrl: assert property (p_dma_ctrl) else $error("dma boot control write lost");

    property p_id_read;
        @(posedge pclk) disable iff (!presetn)
        (rd_stb && clk_en && mapped && word_idx == OFS_CHIP_ID[7:2]) ##1 (psel && penable) |-> prdata == CHIP_ID_VAL;
    endproperty
    a_id_read: assert property (p_id_read) else $error("device id read wrong");

    // further defaults, so a restore that skips any register but set_r[2] or div_r[1] is caught
    property p_restore_rest;
        @(posedge pclk) disable iff (!presetn)
        restore |=> (pll_reference_divider[0] == REF_RST[0]) && (pll_output_divider[3] == OD_RST[3])
                    && (pll_setting[3] == SET_RST[3]) && (dma_ctrl_r == DMA_CTRL_RST);
    endproperty
    a_restore_rest: assert property (p_restore_rest) else $error("restore missed a register");

    // a refused write must leave the dma registers and the pll settings alone
    property p_refused_write;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pready && !mapped)
            |=> $stable(dma_ctrl_r) && $stable(dma_addr_r) && $stable(pll_setting);
    endproperty
    a_refused_write: assert property (p_refused_write) else $error("refused write changed configuration");

    property p_addr_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_go && word_idx == OFS_DMA_ADDR[7:2] && pstrb == 4'hF && !restore)
            |=> dma_boot_address == $past(pwdata);
    endproperty
    a_addr_write: assert property (p_addr_write) else $error("dma boot address write lost");

    // a late setup costs exactly one extra access cycle once the clock runs
    property p_ready_wait;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && clk_en && !pready) |=> pready || !clk_en;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("access phase never answered");

    property p_frozen;
        @(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable(dma_addr_r) && $stable(dma_ctrl_r) && $stable(pll_setting) && $stable(prdata);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while clock enable low");

    c_restore: cover property (@(posedge pclk) disable iff (!presetn) restore);
    c_boot_addr: cover property (@(posedge pclk) disable iff (!presetn) dma_boot_from_address && dma_boot_address != 0);
    c_bypass: cover property (@(posedge pclk) disable iff (!presetn) pll_bypass[2]);
    c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);
    c_stall: cover property (@(posedge pclk) disable iff (!presetn) psel && penable && !pready);
endmodule // pll_dma_cfg_regs
`default_nettype wire

// file: verif/pll_dma_cfg_regs_test.sv
// self-checking testbench of the pll and dma boot configuration bank
`timescale 1ns/1ns
`default_nettype none
module pll_dma_cfg_regs_test
    import pll_dma_cfg_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite, cpu_pll_status;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [NUM_PLL-1:0][12:0] pll_setting;
    logic [NUM_PLL-1:0] pll_bypass;
    logic [NUM_PLL-1:0][3:0] pll_output_divider;
    logic [NUM_PLL-1:0][5:0] pll_reference_divider;
    logic [3:0] dma_irq_nonsecure;
    logic [1:0] dma_periph_req_nonsecure;
    logic dma_manager_nonsecure, dma_boot_from_address;
    logic [31:0] dma_boot_address, rd_v;
    logic err_v;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;

    pll_dma_cfg_regs pll_dma_cfg_regs_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_pll_status(cpu_pll_status),
        .pll_setting(pll_setting), .pll_bypass(pll_bypass), .pll_output_divider(pll_output_divider),
        .pll_reference_divider(pll_reference_divider), .dma_irq_nonsecure(dma_irq_nonsecure),
        .dma_periph_req_nonsecure(dma_periph_req_nonsecure), .dma_manager_nonsecure(dma_manager_nonsecure),
        .dma_boot_from_address(dma_boot_from_address), .dma_boot_address(dma_boot_address)
    );

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a hung handshake must not stall the run forever
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // pready sampled high, or else the bench timeout, ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_v = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle, so the next setup never reassigns psel in this time step
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask

    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, 4'hF);
        chk(what, rd_v, exp);
    endtask

    // every register and output at its default, dma_boot_address output on its low 24 bits only, status pin low
    task automatic defaults_chk;
        for (int i = 0; i < NUM_PLL; i++) begin
            rdc("pll setting reg", 8'(OFS_PLL_SET_BASE + 8 * i), {3'h0, SET_RST[i], 16'h0000});
            rdc("pll divider reg", 8'(OFS_PLL_DIV_BASE + 8 * i), {20'h0, OD_RST[i], 2'h0, REF_RST[i]});
            chk("pll setting out", 32'(pll_setting[i]), 32'(SET_RST[i]));
            chk("pll bypass out", 32'(pll_bypass[i]), 32'h0);
            chk("pll od out", 32'(pll_output_divider[i]), 32'(OD_RST[i]));
            chk("pll ref out", 32'(pll_reference_divider[i]), 32'(REF_RST[i]));
        end
        rdc("dma ctrl reg", OFS_DMA_CTRL, 32'h0000_0000);
        rdc("dma addr reg", OFS_DMA_ADDR, 32'h0000_0000);
        chk("dma out", {dma_irq_nonsecure, dma_periph_req_nonsecure, dma_manager_nonsecure,
            dma_boot_from_address, dma_boot_address[23:0]}, 32'h0);
    endtask

    task automatic dma_chk(input logic [31:0] v, input logic [7:0] exp);
        wr(OFS_DMA_CTRL, v);
        rdc("dma ctrl reg", OFS_DMA_CTRL, v & DMA_CTRL_MASK);
        chk("dma ctrl out", 32'({dma_irq_nonsecure, dma_periph_req_nonsecure, dma_manager_nonsecure,
            dma_boot_from_address}), 32'(exp));
    endtask

    // main sequence
    initial begin
        {psel, penable, pwrite, cpu_pll_status} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        clk_en = 1'b1;
        presetn = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        defaults_chk();
        // all ones into every pll pair: reserved and read-only bits stay clear
        for (int i = 0; i < NUM_PLL; i++) begin
            wr(8'(OFS_PLL_SET_BASE + 8 * i), 32'hFFFF_FFFF);
            wr(8'(OFS_PLL_DIV_BASE + 8 * i), 32'hFFFF_FFFF);
            rdc("pll setting reg", 8'(OFS_PLL_SET_BASE + 8 * i), 32'h1FFF_0001);
            rdc("pll divider reg", 8'(OFS_PLL_DIV_BASE + 8 * i), 32'h0000_0F3F);
            chk("pll outs", {pll_setting[i], pll_bypass[i], pll_output_divider[i], pll_reference_divider[i]},
                32'h00FF_FFFF);
        end
        dma_chk(32'hFFFF_FFFF, 8'hFF);
        dma_chk(32'h000A_0101, 8'hA5);
        dma_chk(32'h0005_0210, 8'h5A);
        // byte lane write keeps the other lanes
        wr(OFS_DMA_ADDR, 32'hDEAD_BEEF);
        xfer(1'b1, OFS_DMA_ADDR, 32'h0000_5500, 4'h2);
        rdc("dma addr reg", OFS_DMA_ADDR, 32'hDEAD_55EF);
        chk("dma addr out", dma_boot_address, 32'hDEAD_55EF);
        // identification registers ignore writes
        wr(OFS_CHIP_ID, 32'h0);
        wr(OFS_PROC_ID, 32'h0);
        rdc("chip id", OFS_CHIP_ID, CHIP_ID_VAL);
        rdc("proc id", OFS_PROC_ID, PROC_ID_VAL);
        // unmapped and misaligned accesses are refused
        xfer(1'b0, 8'h34, 32'h0, 4'hF);
        chk("unmapped err", 32'(err_v), 32'h1);
        chk("unmapped rdata", rd_v, 32'h0);
        xfer(1'b1, 8'h22, 32'hFFFF_FFFF, 4'hF);
        chk("misaligned err", 32'(err_v), 32'h1);
        rdc("dma ctrl kept", OFS_DMA_CTRL, 32'h0005_0210);
        // near-miss key does nothing, exact key restores everything
        wr(OFS_RESTORE, RESTORE_KEY ^ 32'h0000_0001);
        rdc("no restore", OFS_DMA_ADDR, 32'hDEAD_55EF);
        rdc("restore reads zero", OFS_RESTORE, 32'h0);
        // software avoids the restore register, the bench writes the exact key only here to prove it
        wr(OFS_RESTORE, RESTORE_KEY);
        chk("restore err", 32'(err_v), 32'h0);
        defaults_chk();
        // status pin shows at cpu bit 5 and writes cannot change it
        cpu_pll_status <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(OFS_PLL_SET_BASE, 32'h0000_0000);
        rdc("cpu status bit", OFS_PLL_SET_BASE, 32'h0000_0020);
        chk("cpu setting out", 32'(pll_setting[PLL_CPU]), 32'h0);
        // a stalled clock enable holds the access phase open
        clk_en <= 1'b0;
        @(posedge pclk);
        chk("pready stalled", 32'(pready), 32'h0);
        fork
            wr(OFS_DMA_ADDR, 32'h1234_0000);
            begin
                repeat (3) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        rdc("stalled write", OFS_DMA_ADDR, 32'h1234_0000);
        print_verdict();
    end
endmodule // pll_dma_cfg_regs_test
`default_nettype wire
